/* File: logic/ecst_pkg.sv */
// Purpose: Shared constants and types of the ECC self-test engine.
// Assumes: 32-bit APB data, byte addresses, one aligned word per register.
// Notes: Register offsets below are the byte addresses used by the slave.

package ecst_pkg;

    // =========================================================
    // Sizes
    localparam int unsigned ECST_DW = 32;
    localparam int unsigned ECST_AW = 8;
    localparam int unsigned ECST_NIN = 9;
    localparam int unsigned ECST_NDB = 8;
    localparam int unsigned ECST_NDATA = 64;
    localparam int unsigned ECST_NCODE = 72;
    localparam int unsigned ECST_NSYN = 7;
    localparam int unsigned ECST_FLT_W = 2;
    localparam int unsigned ECST_IRQ_W = 3;

    // =========================================================
    // Register offsets and bank span
    localparam logic [7:0] ECST_OFF_CTRL = 8'h00;
    localparam logic [7:0] ECST_OFF_FAULT = 8'h04;
    localparam logic [7:0] ECST_OFF_FCLR = 8'h08;
    localparam logic [7:0] ECST_OFF_ISTAT = 8'h0c;
    localparam logic [7:0] ECST_OFF_IMASK = 8'h10;
    localparam logic [7:0] ECST_OFF_DIN = 8'h20;
    localparam logic [7:0] ECST_OFF_DOUT = 8'h60;
    localparam logic [7:0] ECST_BANK_SPAN = 8'h24;

    // =========================================================
    // Field positions
    localparam int unsigned ECST_CTRL_EN = 0;
    localparam int unsigned ECST_CTRL_SRC = 1;
    localparam int unsigned ECST_CTRL_FUNC = 2;
    localparam int unsigned ECST_CTRL_ETYPE = 3;
    localparam int unsigned ECST_FLT_SEC = 0;
    localparam int unsigned ECST_FLT_DED = 1;
    localparam int unsigned ECST_IRQ_DONE = 0;
    localparam int unsigned ECST_IRQ_SEC = 1;
    localparam int unsigned ECST_IRQ_DED = 2;

    // =========================================================
    // Fixed automatic-mode results
    localparam logic [7:0] ECST_PAD_BYTE = 8'h00;
    localparam logic [63:0] ECST_AUTO_SEC_DOUT = 64'h18c3_ff8a_68a9_8069;
    localparam logic [63:0] ECST_AUTO_DED_DOUT = 64'h0000_0000_0000_0000;
    localparam logic [71:0] ECST_AUTO_ENC_DOUT = 72'hcd_3968_c140_2ea5_ed6d;

    // =========================================================
    // Types
    typedef enum logic [0:0] {
        ECST_IDLE,
        ECST_RUN
    } ecst_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ECST_AW-1:0] paddr;
        logic [ECST_DW-1:0] pwdata;
    } ecst_apb_req_s;

    typedef struct packed {
        logic pready;
        logic [ECST_DW-1:0] prdata;
        logic pslverr;
    } ecst_apb_rsp_s;

    typedef struct packed {
        logic sec;
        logic ded;
        logic [ECST_NDATA-1:0] data;
    } ecst_dec_s;

endpackage : ecst_pkg

/* File: logic/ecst_codec.sv */
// Purpose: Combinational (72,64) SECDED Hamming encoder and decoder.
// Assumes: Parity at position 0 and at powers of two, data elsewhere ascending.
// Notes: Position 0 holds the parity of bits 71 to 1, so the whole 72-bit block has even parity.

`timescale 1ns/1ns

module ecst_codec (
    // Encoder side
    input wire logic [ecst_pkg::ECST_NDATA-1:0] i_data,
    output logic [ecst_pkg::ECST_NCODE-1:0] o_code,
    // Decoder side
    input wire logic [ecst_pkg::ECST_NCODE-1:0] i_code,
    output ecst_pkg::ecst_dec_s o_dec
);
    import ecst_pkg::*;

    // =========================================================
    // Encoder
    function automatic logic [ECST_NCODE-1:0] ecst_encode(input logic [ECST_NDATA-1:0] d);
        logic [ECST_NCODE-1:0] c;
        int unsigned k;
        c = '0;
        k = 0;
        for (int unsigned p = 1; p < ECST_NCODE; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int unsigned b = 0; b < ECST_NSYN; b++) begin
            for (int unsigned p = 1; p < ECST_NCODE; p++) begin
                if (p[b] && ((p & (p - 1)) != 0)) begin
                    c[1 << b] = c[1 << b] ^ c[p];
                end
            end
        end
        c[0] = ^c[ECST_NCODE-1:1];
        return c;
    endfunction : ecst_encode

    // =========================================================
    // Decoder
    function automatic ecst_dec_s ecst_decode(input logic [ECST_NCODE-1:0] c);
        ecst_dec_s r;
        logic [ECST_NCODE-1:0] f;
        logic [ECST_NSYN-1:0] s;
        logic odd;
        int unsigned k;
        r = '0;
        f = c;
        s = '0;
        k = 0;
        for (int unsigned p = 1; p < ECST_NCODE; p++) begin
            if (c[p]) begin
                s = s ^ p[ECST_NSYN-1:0];
            end
        end
        odd = ^c;
        if (odd && (s < ECST_NCODE)) begin
            // A lone flipped bit, including the overall parity bit, is corrected.
            r.sec = 1'b1;
            f[s] = ~f[s];
        end else if (odd || (s != '0)) begin
            r.ded = 1'b1;
        end
        for (int unsigned p = 1; p < ECST_NCODE; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[k] = f[p] & ~r.ded;
                k++;
            end
        end
        return r;
    endfunction : ecst_decode

    assign o_code = ecst_encode(i_data);
    assign o_dec = ecst_decode(i_code);

endmodule : ecst_codec

/* File: logic/ecst_engine.sv */
// Purpose: ECC self-test engine with an APB register file and one interrupt.
// Assumes: APB master keeps address and data stable through the access phase.
// Notes: Zero wait states; results are latched at the enabling write.
//
// The register addresses and the APB register port were decided locally.

`timescale 1ns/1ns

module ecst_engine (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // APB slave
    input wire ecst_pkg::ecst_apb_req_s i_apb,
    output ecst_pkg::ecst_apb_rsp_s o_apb,
    // Interrupt
    output logic o_irq
);
    import ecst_pkg::*;

    // =========================================================
    // State
    typedef struct packed {
        ecst_state_e st;
        logic src;
        logic func;
        logic etype;
        logic [ECST_FLT_W-1:0] fault;
        logic [ECST_IRQ_W-1:0] ist;
        logic [ECST_IRQ_W-1:0] imask;
        logic [ECST_NIN-1:0][7:0] din;
        logic [ECST_NIN-1:0][7:0] dout;
        logic [ECST_DW-1:0] prdata;
    } ecst_regs_s;

    ecst_regs_s regs_ff;
    ecst_regs_s nxt_regs;

    // =========================================================
    // Address decoding
    function automatic logic in_bank(
        input logic [ECST_AW-1:0] a,
        input logic [ECST_AW-1:0] base
    );
        logic hit;
        hit = (a >= base) && (a < (base + ECST_BANK_SPAN));
        return hit && (a[1:0] == '0);
    endfunction : in_bank

    function automatic logic [ECST_AW-3:0] bank_idx(
        input logic [ECST_AW-1:0] a,
        input logic [ECST_AW-1:0] base
    );
        logic [ECST_AW-1:0] off;
        off = a - base;
        return off[ECST_AW-1:2];
    endfunction : bank_idx

    function automatic logic mapped(input logic [ECST_AW-1:0] a);
        logic hit;
        hit = (a == ECST_OFF_CTRL) || (a == ECST_OFF_FAULT);
        hit = hit || (a == ECST_OFF_FCLR) || (a == ECST_OFF_ISTAT);
        hit = hit || (a == ECST_OFF_IMASK);
        hit = hit || in_bank(a, ECST_OFF_DIN) || in_bank(a, ECST_OFF_DOUT);
        return hit;
    endfunction : mapped

    // Control read-back; enable reads as one only while a test is running.
    function automatic logic [ECST_DW-1:0] ctrl_word(input ecst_regs_s r);
        logic [ECST_DW-1:0] w;
        w = '0;
        w[ECST_CTRL_EN] = (r.st == ECST_RUN);
        w[ECST_CTRL_SRC] = r.src;
        w[ECST_CTRL_FUNC] = r.func;
        w[ECST_CTRL_ETYPE] = r.etype;
        return w;
    endfunction : ctrl_word

    // A bank byte sits in the low lane of its word; the upper lanes read zero.
    function automatic logic [ECST_DW-1:0] byte_word(input logic [7:0] b);
        logic [ECST_DW-1:0] w;
        w = '0;
        w[7:0] = b;
        return w;
    endfunction : byte_word

    function automatic logic [ECST_DW-1:0] rd_word(
        input ecst_regs_s r,
        input logic [ECST_AW-1:0] a
    );
        logic [ECST_DW-1:0] w;
        w = '0;
        if (a == ECST_OFF_CTRL) begin
            w = ctrl_word(r);
        end else if (a == ECST_OFF_FAULT) begin
            w[ECST_FLT_W-1:0] = r.fault;
        end else if (a == ECST_OFF_ISTAT) begin
            w[ECST_IRQ_W-1:0] = r.ist;
        end else if (a == ECST_OFF_IMASK) begin
            w[ECST_IRQ_W-1:0] = r.imask;
        end else if (in_bank(a, ECST_OFF_DIN)) begin
            w = byte_word(r.din[bank_idx(a, ECST_OFF_DIN)]);
        end else if (in_bank(a, ECST_OFF_DOUT)) begin
            w = byte_word(r.dout[bank_idx(a, ECST_OFF_DOUT)]);
        end
        return w;
    endfunction : rd_word

    // =========================================================
    // Bus qualifiers
    logic acc;
    logic wr_en;
    logic rd_setup;
    logic wr_ctrl;
    logic start;
    logic stop;
    logic [ECST_AW-1:0] addr;
    logic [ECST_DW-1:0] wdata;

    assign addr = i_apb.paddr;
    assign wdata = i_apb.pwdata;
    assign acc = i_apb.psel && i_apb.penable;
    assign wr_en = acc && i_apb.pwrite && mapped(addr);
    assign rd_setup = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
    assign wr_ctrl = wr_en && (addr == ECST_OFF_CTRL);
    assign start = wr_ctrl && wdata[ECST_CTRL_EN];
    assign stop = wr_ctrl && !wdata[ECST_CTRL_EN];

    // Unmapped and misaligned words answer with an error and never write.
    logic bad_addr;

    assign bad_addr = acc && !mapped(addr);

    // =========================================================
    // Codec
    // The encoder sees only the eight data bytes; the ninth input byte is
    // read by the decoder alone.
    logic [ECST_NCODE-1:0] enc_code;
    ecst_dec_s dec_res;

    ecst_codec u_codec (
        .i_data(regs_ff.din[ECST_NDB-1:0]),
        .o_code(enc_code),
        .i_code(regs_ff.din),
        .o_dec(dec_res)
    );

    // =========================================================
    // Register write strobes
    // Writes to the output bank and to the fault status word are taken
    // and dropped, so software sees no error for them.
    logic wr_fclr;
    logic wr_istat;
    logic wr_imask;
    logic wr_din;
    logic [ECST_AW-3:0] din_idx;

    assign wr_fclr = wr_en && (addr == ECST_OFF_FCLR);
    assign wr_istat = wr_en && (addr == ECST_OFF_ISTAT);
    assign wr_imask = wr_en && (addr == ECST_OFF_IMASK);
    assign wr_din = wr_en && in_bank(addr, ECST_OFF_DIN);
    assign din_idx = bank_idx(addr, ECST_OFF_DIN);

    // =========================================================
    // Test configuration
    // The run uses the bits of the enabling word itself, not the stored ones.
    logic w_src;
    logic w_func;
    logic w_etype;

    assign w_src = wdata[ECST_CTRL_SRC];
    assign w_func = wdata[ECST_CTRL_FUNC];
    assign w_etype = wdata[ECST_CTRL_ETYPE];

    // =========================================================
    // Automatic results
    // The built-in patterns never look at the input bank, so a stale or
    // half-written bank cannot disturb an automatic run.
    logic [ECST_NIN-1:0][7:0] auto_res;
    logic [ECST_FLT_W-1:0] auto_flt;

    always_comb begin
        auto_res = '0;
        auto_flt = '0;
        if (w_func) begin
            auto_res = ECST_AUTO_ENC_DOUT;
        end else if (w_etype) begin
            auto_res = {ECST_PAD_BYTE, ECST_AUTO_DED_DOUT};
            auto_flt[ECST_FLT_DED] = 1'b1;
        end else begin
            auto_res = {ECST_PAD_BYTE, ECST_AUTO_SEC_DOUT};
            auto_flt[ECST_FLT_SEC] = 1'b1;
        end
    end

    // =========================================================
    // Manual results
    // The manual decoder reports the class it finds in the bank, whatever
    // the error-type select says; that bit only steers the built-in test.
    logic [ECST_NIN-1:0][7:0] man_res;
    logic [ECST_FLT_W-1:0] man_flt;

    always_comb begin
        man_res = '0;
        man_flt = '0;
        if (w_func) begin
            man_res = enc_code;
        end else begin
            man_res = {ECST_PAD_BYTE, dec_res.data};
            man_flt[ECST_FLT_SEC] = dec_res.sec;
            man_flt[ECST_FLT_DED] = dec_res.ded;
        end
    end

    // =========================================================
    // Source selection
    // Source select picks the built-in run or the software-loaded bank.
    logic [ECST_NIN-1:0][7:0] res;
    logic [ECST_FLT_W-1:0] res_flt;

    assign res = w_src ? man_res : auto_res;
    assign res_flt = w_src ? man_flt : auto_flt;

    // =========================================================
    // Sticky bits
    // Set wins over clear, so an event that lands on the clearing write is
    // still seen by software.
    function automatic logic [ECST_IRQ_W-1:0] sticky(
        input logic [ECST_IRQ_W-1:0] cur,
        input logic [ECST_IRQ_W-1:0] clr,
        input logic [ECST_IRQ_W-1:0] set
    );
        return (cur & ~clr) | set;
    endfunction : sticky

    // =========================================================
    // Test events
    // Each enabling write runs the configured test once; an encoder run
    // never reaches the error flags.
    logic [ECST_FLT_W-1:0] flt_set;
    logic [ECST_FLT_W-1:0] flt_clr;
    logic [ECST_IRQ_W-1:0] irq_set;
    logic [ECST_IRQ_W-1:0] irq_clr;

    assign flt_set = (start && !w_func) ? res_flt : '0;
    assign flt_clr = wr_fclr ? wdata[ECST_FLT_W-1:0] : '0;
    assign irq_clr = wr_istat ? wdata[ECST_IRQ_W-1:0] : '0;

    always_comb begin
        irq_set = '0;
        irq_set[ECST_IRQ_DONE] = start;
        irq_set[ECST_IRQ_SEC] = flt_set[ECST_FLT_SEC];
        irq_set[ECST_IRQ_DED] = flt_set[ECST_FLT_DED];
    end

    // =========================================================
    // Next-state logic
    always_comb begin
        nxt_regs = regs_ff;

        // Read data is captured in the setup phase for a zero-wait access.
        if (rd_setup) begin
            nxt_regs.prdata = rd_word(regs_ff, addr);
        end

        case (regs_ff.st)
            ECST_IDLE: begin
                if (start) begin
                    nxt_regs.st = ECST_RUN;
                end
            end
            ECST_RUN: begin
                if (stop) begin
                    nxt_regs.st = ECST_IDLE;
                end
            end
            default: begin
                nxt_regs.st = ECST_IDLE;
            end
        endcase

        if (wr_ctrl) begin
            nxt_regs.src = w_src;
            nxt_regs.func = w_func;
            nxt_regs.etype = w_etype;
        end

        // Outputs latch at the enabling write and hold through a later disable.
        if (start) begin
            nxt_regs.dout = res;
        end
        if (wr_imask) begin
            nxt_regs.imask = wdata[ECST_IRQ_W-1:0];
        end
        if (wr_din) begin
            nxt_regs.din[din_idx] = wdata[7:0];
        end

        // A detection in the same cycle as its clear wins.
        nxt_regs.fault = ECST_FLT_W'(sticky(ECST_IRQ_W'(regs_ff.fault), ECST_IRQ_W'(flt_clr),
            ECST_IRQ_W'(flt_set)));
        nxt_regs.ist = sticky(regs_ff.ist, irq_clr, irq_set);
    end

    // =========================================================
    // Registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            regs_ff <= '0;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // =========================================================
    // Outputs
    always_comb begin
        o_apb = '0;
        o_apb.pready = acc;
        o_apb.prdata = regs_ff.prdata;
        o_apb.pslverr = bad_addr;
    end

    // =========================================================
    // Interrupt
    // A level output: it stays high until every unmasked status bit is cleared.
    logic [ECST_IRQ_W-1:0] irq_pend;

    assign irq_pend = regs_ff.ist & regs_ff.imask;
    assign o_irq = |irq_pend;

endmodule : ecst_engine

/* File: bench/ecst_engine_properties.sv */
// Purpose: Bus-level checks of the ECC self-test engine.
// Assumes: Zero wait states and a read set up right after the enabling write.
// Notes: Sees only the top-level ports.

`timescale 1ns/1ns

module ecst_engine_properties (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Watched bus
    input wire ecst_pkg::ecst_apb_req_s i_apb,
    input wire ecst_pkg::ecst_apb_rsp_s o_apb,
    // Watched interrupt
    input wire logic o_irq
);
    import ecst_pkg::*;
    // ==========================================================
    // Sequences
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_wr(logic [7:0] a, logic [3:0] d);
        i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == a && i_apb.pwdata[3:0] == d;
    endsequence
    sequence s_rd(logic [7:0] a);
        i_apb.psel && !i_apb.penable && !i_apb.pwrite && i_apb.paddr == a
        ##1 i_apb.psel && i_apb.penable;
    endsequence
    // ==========================================================
    // Properties
    a_zero_wait: assert property (i_apb.psel && i_apb.penable |-> o_apb.pready)
        else $error("access phase without ready");
    a_err_in_access: assert property (o_apb.pslverr |-> i_apb.psel && i_apb.penable)
        else $error("error outside access phase");
    a_unmapped_err: assert property (i_apb.psel && i_apb.penable && i_apb.paddr == 8'h14
        |-> o_apb.pslverr)
        else $error("unmapped access without error");
    a_auto_sec_flag: assert property (s_wr(ECST_OFF_CTRL, 4'h1) ##1 s_rd(ECST_OFF_FAULT)
        |-> o_apb.prdata[0])
        else $error("single flag missing after automatic test");
    a_auto_ded_flag: assert property (s_wr(ECST_OFF_CTRL, 4'h9) ##1 s_rd(ECST_OFF_FAULT)
        |-> o_apb.prdata[1])
        else $error("double flag missing after automatic test");
    a_auto_enc_out: assert property (s_wr(ECST_OFF_CTRL, 4'h5) ##1 s_rd(ECST_OFF_DOUT)
        |-> o_apb.prdata[7:0] == 8'h6d)
        else $error("automatic encoder byte zero wrong");
    a_enable_reads: assert property (s_wr(ECST_OFF_CTRL, 4'h7) ##1 s_rd(ECST_OFF_CTRL)
        |-> o_apb.prdata[0])
        else $error("enable not seen after start");
    a_clear_flags: assert property (s_wr(ECST_OFF_FCLR, 4'h3) ##1 s_rd(ECST_OFF_FAULT)
        |-> o_apb.prdata[1:0] == 2'h0)
        else $error("flags not cleared");
    a_irq_on_write: assert property ($rose(o_irq)
        |-> $past(i_apb.psel && i_apb.penable && i_apb.pwrite))
        else $error("interrupt rose without a register write");
endmodule : ecst_engine_properties

bind ecst_engine ecst_engine_properties u_props (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb), .o_irq(o_irq));

/* File: bench/tb_ecst_engine.sv */
// Purpose: Self-checking bench of the ECC self-test engine over APB.
// Assumes: One transfer follows another at once unless idle is called.
// Notes: Expected manual-mode codewords come from the bench's own encoder; automatic ones from the package.

`timescale 1ns/1ns

module tb_ecst_engine;
    import ecst_pkg::*;
    logic i_mclk;
    logic i_rst;
    ecst_apb_req_s req;
    ecst_apb_rsp_s rsp;
    logic o_irq;
    logic last_err;
    int n_mismatch = 0;
    int cmp_count = 0;
    ecst_engine dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_apb(req), .o_apb(rsp), .o_irq(o_irq));
    // ==========================================================
    // Helpers
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge i_mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
        end while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        last_err = rsp.pslverr;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rdc
    task automatic idle();
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge i_mclk);
    endtask : idle
    task automatic load(input logic [71:0] v);
        for (int i = 0; i < 9; i++) wr(ECST_OFF_DIN + 8'(4 * i), {24'h0, v[8*i+:8]});
    endtask : load
    task automatic outs(input logic [71:0] e);
        for (int i = 0; i < 9; i++) rdc(ECST_OFF_DOUT + 8'(4 * i), {24'h0, e[8*i+:8]});
    endtask : outs
    function automatic logic [71:0] enc(input logic [63:0] d);
        logic [71:0] c;
        int j;
        c = '0;
        j = 0;
        for (int p = 3; p < 72; p++) if ((p & (p - 1)) != 0) begin
            c[p] = d[j];
            j++;
        end
        for (int k = 0; k < 7; k++)
            for (int p = 3; p < 72; p++) if (p[k] && p != (1 << k)) c[1 << k] ^= c[p];
        c[0] = ^c;
        return c;
    endfunction : enc
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] offs [6] = '{ECST_OFF_CTRL, ECST_OFF_FAULT, ECST_OFF_ISTAT,
                                 ECST_OFF_IMASK, ECST_OFF_DIN, ECST_OFF_DOUT};
        foreach (offs[i]) rdc(offs[i], 32'h0);
    endtask : t_reset
    task automatic t_auto();
        load(72'ha5_5a5a_5a5a_5a5a_5a5a);
        wr(ECST_OFF_FCLR, 32'h3);
        wr(ECST_OFF_CTRL, 32'h1);
        rdc(ECST_OFF_FAULT, 32'h1);
        outs({8'h0, ECST_AUTO_SEC_DOUT});
        wr(ECST_OFF_CTRL, 32'h5);
        outs(ECST_AUTO_ENC_DOUT);
        rdc(ECST_OFF_FAULT, 32'h1);
        wr(ECST_OFF_CTRL, 32'h0);
        wr(ECST_OFF_FCLR, 32'h3);
        wr(ECST_OFF_CTRL, 32'h9);
        rdc(ECST_OFF_FAULT, 32'h2);
        outs(72'h0);
        wr(ECST_OFF_CTRL, 32'hd);
        outs(ECST_AUTO_ENC_DOUT);
        wr(ECST_OFF_CTRL, 32'h0);
        rdc(ECST_OFF_CTRL, 32'h0);
        outs(ECST_AUTO_ENC_DOUT);
        wr(ECST_OFF_FCLR, 32'h1);
        rdc(ECST_OFF_FAULT, 32'h2);
        wr(ECST_OFF_FCLR, 32'h3);
        rdc(ECST_OFF_FAULT, 32'h0);
    endtask : t_auto
    task automatic t_manual(input logic [63:0] d);
        logic [71:0] c;
        c = enc(d);
        load({8'h0, d});
        wr(ECST_OFF_CTRL, 32'h7);
        rdc(ECST_OFF_CTRL, 32'h7);
        outs(c);
        wr(ECST_OFF_CTRL, 32'h0);
        wr(ECST_OFF_FCLR, 32'h3);
        load(c);
        wr(ECST_OFF_CTRL, 32'h3);
        rdc(ECST_OFF_FAULT, 32'h0);
        outs({8'h0, d});
        load(c ^ (72'h1 << 13));
        wr(ECST_OFF_CTRL, 32'hb);
        rdc(ECST_OFF_FAULT, 32'h1);
        outs({8'h0, d});
        wr(ECST_OFF_CTRL, 32'h0);
        wr(ECST_OFF_FCLR, 32'h3);
        load(c ^ (72'h1 << 13) ^ (72'h1 << 40));
        wr(ECST_OFF_CTRL, 32'h3);
        rdc(ECST_OFF_FAULT, 32'h2);
        outs(72'h0);
    endtask : t_manual
    task automatic t_irq_err();
        logic [31:0] r;
        wr(ECST_OFF_ISTAT, 32'h7);
        wr(ECST_OFF_IMASK, 32'h1);
        wr(ECST_OFF_CTRL, 32'h5);
        idle();
        chk({31'h0, o_irq}, 32'h1);
        wr(ECST_OFF_ISTAT, 32'h1);
        idle();
        chk({31'h0, o_irq}, 32'h0);
        wr(ECST_OFF_CTRL, 32'h5);
        wr(ECST_OFF_IMASK, 32'h0);
        idle();
        chk({31'h0, o_irq}, 32'h0);
        rdc(ECST_OFF_ISTAT, 32'h1);
        wr(ECST_OFF_CTRL, 32'h0);
        wr(ECST_OFF_FCLR, 32'h3);
        wr(ECST_OFF_IMASK, 32'h4);
        wr(ECST_OFF_CTRL, 32'h9);
        rdc(ECST_OFF_ISTAT, 32'h5);
        chk({31'h0, o_irq}, 32'h1);
        xfer(1'b0, 8'h22, 32'h0, r);
        chk({31'h0, last_err}, 32'h1);
        xfer(1'b0, 8'h14, 32'h0, r);
        chk({31'h0, last_err}, 32'h1);
        chk(r, 32'h0);
    endtask : t_irq_err
    // ==========================================================
    // Main sequence
    initial begin
        i_rst = 1'b1;
        req = '0;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        t_reset();
        t_auto();
        t_manual(64'h0123_4567_89ab_cdef);
        t_manual(64'hffff_0000_8000_0001);
        t_irq_err();
        idle();
        summarize();
    end
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule : tb_ecst_engine
